// [rtl/ctxs_pkg.sv]
// Package of constants and types for the transmit mailbox status flags.
package ctxs_pkg;

    // ************************************************************
    // Register map
    // ************************************************************

    // Byte offset of the status word inside the block window.
    localparam logic [11:0] CTXS_STATUS_OFS = 12'h008;
    // Number of transmit mailboxes.
    localparam int CTXS_MBX_NUM = 3;
    // Distance in bits between the fields of two mailboxes.
    localparam int CTXS_MBX_STRIDE = 8;
    // Bit positions of the fields of mailbox 0; others add the stride.
    localparam int CTXS_BIT_REQ_DONE = 0;
    localparam int CTXS_BIT_TX_OK = 1;
    localparam int CTXS_BIT_ARB_LOST = 2;
    localparam int CTXS_BIT_TX_ERROR = 3;
    localparam int CTXS_BIT_ABORT_REQ = 7;
    // Value of every flag after reset.
    localparam logic [2:0] CTXS_FLAGS_RST = 3'h0;
    // Read data after reset and for unmapped reads.
    localparam logic [31:0] CTXS_RDATA_RST = 32'h0000_0000;

    // ************************************************************
    // Types
    // ************************************************************

    // Data phase kinds of the bus slave.
    typedef enum logic [0:0] {
        CTXS_PH_IDLE = 1'b0,
        CTXS_PH_WRITE = 1'b1
    } ctxs_phase_type;

    // Events and levels from the transmit engine, one bit per mailbox.
    typedef struct packed {
        logic [2:0] req;
        logic [2:0] done;
        logic [2:0] ok;
        logic [2:0] arb;
        logic [2:0] err;
        logic [2:0] pend;
    } ctxs_evt_type;

    // Whole state of the block.
    typedef struct packed {
        logic [2:0] req_done;
        logic [2:0] tx_ok;
        logic [2:0] arb_lost;
        logic [2:0] tx_error;
        logic [2:0] abort_req;
        ctxs_phase_type phase;
        logic hready;
        logic [31:0] rdata;
    } ctxs_state_type;

    // State after reset.
    localparam ctxs_state_type CTXS_STATE_RST = '{
        req_done: CTXS_FLAGS_RST,
        tx_ok: CTXS_FLAGS_RST,
        arb_lost: CTXS_FLAGS_RST,
        tx_error: CTXS_FLAGS_RST,
        abort_req: CTXS_FLAGS_RST,
        phase: CTXS_PH_IDLE,
        hready: 1'b1,
        rdata: CTXS_RDATA_RST
    };

endpackage : ctxs_pkg

// [rtl/ctxs_top.sv]
// Transmit mailbox status flags of a CAN controller behind an AHB-Lite slave.
// Bus and timing notes
// The status word is one AHB-Lite slave register answered with no wait states. Read data is
// captured when the address phase is taken, so a read returns the flags as they stood then.
// A write acts in its data phase and its effect shows from the following cycle.
// Hardware events win over a software write of one in the same cycle: a lost event cannot be
// recovered, while a missed clear only costs software a second write.
// The abort bit rises only while the engine reports a waiting message, and it falls as soon as
// the engine drops that message, whether it was sent or aborted.
`timescale 1ns/1ps

module ctxs_top (
    // Clock and reset.
    input wire logic CLOCK,
    input wire logic SYS_RST,
    // AHB-Lite slave port.
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    // Transmit engine side.
    input wire ctxs_pkg::ctxs_evt_type TX_EVT,
    output logic [2:0] ABORT_REQ
);
    import ctxs_pkg::*;

    ctxs_state_type s_r;
    ctxs_state_type s_nxt;
    logic addr_ok;
    logic wr_hit;
    logic map_hit;

    // ************************************************************
    // Status word assembly
    // ************************************************************

    // Builds the readable word; every bit not placed here stays zero.
    function automatic logic [31:0] pack_status(input ctxs_state_type st);
        logic [31:0] w;
        int b;
        w = 32'h0000_0000;
        for (int m = 0; m < CTXS_MBX_NUM; m++) begin
            b = m * CTXS_MBX_STRIDE;
            w[b + CTXS_BIT_REQ_DONE] = st.req_done[m];
            w[b + CTXS_BIT_TX_OK] = st.tx_ok[m];
            w[b + CTXS_BIT_ARB_LOST] = st.arb_lost[m];
            w[b + CTXS_BIT_TX_ERROR] = st.tx_error[m];
            w[b + CTXS_BIT_ABORT_REQ] = st.abort_req[m];
        end
        return w;
    endfunction : pack_status

    // ************************************************************
    // Next state
    // ************************************************************

    // Address phase decode; only whole-word transfers are mapped.
    assign addr_ok = HSEL && HTRANS[1] && HREADY;
    assign wr_hit = (s_r.phase == CTXS_PH_WRITE);
    assign map_hit = (HADDR[11:0] == CTXS_STATUS_OFS) && (HSIZE == 3'h2);

    // Hardware sets win over software clears so no event is lost.
    always_comb begin
        int b;
        logic [2:0] w1;
        s_nxt = s_r;
        b = 0;
        w1 = 3'h0;
        s_nxt.hready = 1'b1;
        for (int m = 0; m < CTXS_MBX_NUM; m++) begin
            b = m * CTXS_MBX_STRIDE;
            // Write-one bits of this mailbox in the data phase.
            w1[0] = wr_hit && HWDATA[b + CTXS_BIT_REQ_DONE];
            w1[1] = wr_hit && HWDATA[b + CTXS_BIT_TX_OK];
            w1[2] = wr_hit && HWDATA[b + CTXS_BIT_ARB_LOST];
            if (TX_EVT.done[m]) begin
                s_nxt.req_done[m] = 1'b1;
            end else if (TX_EVT.req[m] || w1[0]) begin
                s_nxt.req_done[m] = 1'b0;
            end
            if (TX_EVT.ok[m]) begin
                s_nxt.tx_ok[m] = 1'b1;
            end else if (w1[1]) begin
                s_nxt.tx_ok[m] = 1'b0;
            end
            if (TX_EVT.arb[m]) begin
                s_nxt.arb_lost[m] = 1'b1;
            end else if (w1[2]) begin
                s_nxt.arb_lost[m] = 1'b0;
            end
            if (TX_EVT.err[m]) begin
                s_nxt.tx_error[m] = 1'b1;
            end else if (wr_hit && HWDATA[b + CTXS_BIT_TX_ERROR]) begin
                s_nxt.tx_error[m] = 1'b0;
            end
            // A zero written here is simply not acted on.
            if (wr_hit && HWDATA[b + CTXS_BIT_ABORT_REQ] && TX_EVT.pend[m]) begin
                s_nxt.abort_req[m] = 1'b1;
            end else if (!TX_EVT.pend[m]) begin
                s_nxt.abort_req[m] = 1'b0;
            end
        end
        // Zero wait states: read data is sampled at the address edge.
        s_nxt.phase = CTXS_PH_IDLE;
        if (addr_ok && map_hit) begin
            if (HWRITE) begin
                s_nxt.phase = CTXS_PH_WRITE;
            end else begin
                s_nxt.rdata = pack_status(s_r);
            end
        end else if (addr_ok && !HWRITE) begin
            s_nxt.rdata = CTXS_RDATA_RST;
        end
    end

    // ************************************************************
    // State register and outputs
    // ************************************************************

    // Synchronous reset loads the constant reset state.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            s_r <= CTXS_STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs other than HRESP, which is tied low, come straight from the state register.
    assign HREADYOUT = s_r.hready;
    assign HRESP = 1'b0;
    assign HRDATA = s_r.rdata;
    assign ABORT_REQ = s_r.abort_req;

    // ************************************************************
    // Assertions
    // ************************************************************

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    // A mapped read address phase.
    sequence seq_rd_addr;
        addr_ok && !HWRITE && HADDR[11:0] == CTXS_STATUS_OFS && HSIZE == 3'h2;
    endsequence

    // A mapped write address phase followed by its data phase.
    sequence seq_wr_cycle;
        addr_ok && HWRITE && HADDR[11:0] == CTXS_STATUS_OFS && HSIZE == 3'h2 ##1 1'b1;
    endsequence

    // A read address phase that misses the status word or has the wrong size.
    sequence seq_rd_miss;
        addr_ok && !HWRITE && !map_hit;
    endsequence

    // A write address phase that misses the status word or has the wrong size.
    sequence seq_wr_miss;
        addr_ok && HWRITE && !map_hit;
    endsequence

    // ************************************************************
    // Per-mailbox flag checks
    // ************************************************************

    // Clear checks leave out the cycle of a hardware event, since the set wins there.
    genvar g;
    generate
        for (g = 0; g < CTXS_MBX_NUM; g++) begin : g_chk
            // A finished request raises request-done, even against a clear.
            a_done_sets: assert property (
                TX_EVT.done[g] |=> s_r.req_done[g])
                else $error("request-done flag did not set");
            // A new request drops request-done unless it finished in the same cycle.
            a_req_clears: assert property (
                TX_EVT.req[g] && !TX_EVT.done[g] |=> !s_r.req_done[g])
                else $error("request-done flag not cleared by new request");
            // A write of one drops request-done.
            a_w1c_done: assert property (
                seq_wr_cycle ##0 HWDATA[g * 8] && !TX_EVT.done[g] |=> !s_r.req_done[g])
                else $error("request-done flag not cleared by write");
            // Without a request or a write, a set request-done stays set.
            a_done_holds: assert property (
                s_r.req_done[g] && !wr_hit && !TX_EVT.req[g] |=> s_r.req_done[g])
                else $error("request-done flag cleared without a cause");
            // A successful attempt raises transmit-ok.
            a_ok_sets: assert property (
                TX_EVT.ok[g] |=> s_r.tx_ok[g])
                else $error("transmit-ok flag did not set");
            // A write of one drops transmit-ok.
            a_ok_clears: assert property (
                seq_wr_cycle ##0 HWDATA[g * 8 + 1] && !TX_EVT.ok[g] |=> !s_r.tx_ok[g])
                else $error("transmit-ok flag not cleared by write");
            // Transmit-ok is never dropped by hardware.
            a_ok_holds: assert property (
                s_r.tx_ok[g] && !wr_hit |=> s_r.tx_ok[g])
                else $error("transmit-ok flag cleared without a write");
            // Lost arbitration raises arbitration-lost.
            a_arb_sets: assert property (
                TX_EVT.arb[g] |=> s_r.arb_lost[g])
                else $error("arbitration-lost flag did not set");
            // A write of one drops arbitration-lost.
            a_arb_clears: assert property (
                seq_wr_cycle ##0 HWDATA[g * 8 + 2] && !TX_EVT.arb[g] |=> !s_r.arb_lost[g])
                else $error("arbitration-lost flag not cleared by write");
            // Only a write can drop arbitration-lost.
            a_arb_holds: assert property (
                s_r.arb_lost[g] && !wr_hit |=> s_r.arb_lost[g])
                else $error("arbitration-lost flag cleared without a write");
            // A failed transmission raises transmit-error.
            a_err_sets: assert property (
                TX_EVT.err[g] |=> s_r.tx_error[g])
                else $error("transmit-error flag did not set");
            // A write of one drops transmit-error.
            a_err_clears: assert property (
                seq_wr_cycle ##0 HWDATA[g * 8 + 3] && !TX_EVT.err[g] |=> !s_r.tx_error[g])
                else $error("transmit-error flag not cleared by write");
            // Only a write can drop transmit-error.
            a_err_holds: assert property (
                s_r.tx_error[g] && !wr_hit |=> s_r.tx_error[g])
                else $error("transmit-error flag cleared without a write");
            // An abort bit never stands for an empty mailbox.
            a_abort_idle: assert property (
                !TX_EVT.pend[g] |=> !s_r.abort_req[g])
                else $error("abort bit set with no waiting message");
            // A write of one to the abort bit of a waiting mailbox raises it.
            a_abort_sets: assert property (
                seq_wr_cycle ##0 HWDATA[g * 8 + 7] && TX_EVT.pend[g] |=> ABORT_REQ[g])
                else $error("abort bit did not set on write of one");
            // The abort bit never rises except by a write.
            a_abort_rise: assert property (
                $rose(ABORT_REQ[g]) |-> $past(wr_hit))
                else $error("abort bit rose without a write");
            // The abort bit stays up while the message still waits.
            a_abort_holds: assert property (
                ABORT_REQ[g] && TX_EVT.pend[g] |=> ABORT_REQ[g])
                else $error("abort bit dropped while the message still waits");
            // The read word carries transmit-ok and arbitration-lost at their own bits.
            a_read_flags: assert property (
                seq_rd_addr |=> HRDATA[g * 8 + 1] == $past(s_r.tx_ok[g])
                    && HRDATA[g * 8 + 2] == $past(s_r.arb_lost[g]))
                else $error("transmit-ok or arbitration-lost at the wrong bit");
            // The read word carries transmit-error and the abort bit at their own bits.
            a_read_err: assert property (
                seq_rd_addr |=> HRDATA[g * 8 + 3] == $past(s_r.tx_error[g])
                    && HRDATA[g * 8 + 7] == $past(s_r.abort_req[g]))
                else $error("transmit-error or abort bit at the wrong bit");
        end
    endgenerate

    // ************************************************************
    // Bus checks
    // ************************************************************

    // Every reserved range of the status word reads as zero.
    a_read_word: assert property (
        seq_rd_addr |=> HRDATA[6:4] == 3'h0 && HRDATA[14:12] == 3'h0
            && HRDATA[22:20] == 3'h0 && HRDATA[31:24] == 8'h00)
        else $error("reserved status bits read as nonzero");
    // Request-done of mailbox 0 sits at bit 0.
    a_read_bit0: assert property (
        seq_rd_addr |=> HRDATA[0] == $past(s_r.req_done[0]))
        else $error("request-done of mailbox 0 not at bit 0");
    // Transmit-error of mailbox 2 sits at bit 19.
    a_read_bit19: assert property (
        seq_rd_addr |=> HRDATA[19] == $past(s_r.tx_error[2]))
        else $error("transmit-error of mailbox 2 not at bit 19");
    // A read that misses the status word returns zero.
    a_rd_miss: assert property (
        seq_rd_miss |=> HRDATA == CTXS_RDATA_RST)
        else $error("refused read returned nonzero data");
    // A write that misses the status word never opens a write data phase.
    a_wr_miss: assert property (
        seq_wr_miss |=> !wr_hit)
        else $error("refused write reached the flags");
    // Read data stands until the next read address phase is taken.
    a_rdata_holds: assert property (
        !(addr_ok && !HWRITE) |=> $stable(HRDATA))
        else $error("read data changed without a read");
    // This slave never inserts wait states and always answers OKAY.
    a_bus_ready: assert property (
        HREADYOUT && !HRESP)
        else $error("slave must always be ready with OKAY");

endmodule : ctxs_top

// [test/ctxs_engine_model.sv]
// Behavioural transmit engine that feeds mailbox events to the status block.
`timescale 1ns/1ps
module ctxs_engine_model
    import ctxs_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Commands from the bench: kind 0 sends, 1 loses arbitration, 2 fails.
    input wire logic [2:0] go,
    input wire logic [2:0] fin,
    input wire logic [1:0] kind,
    // Abort bits from the block and events back to it.
    input wire logic [2:0] abort_req,
    output ctxs_evt_type evt
);
    // Pulses last one cycle; pend stands until the message leaves the queue.
    always_ff @(posedge clk) begin
        evt <= {go, 12'h000, evt.pend};
        for (int m = 0; m < 3; m++) begin
            if (go[m]) begin
                evt.pend[m] <= 1'b1;
            end else if (evt.pend[m] && abort_req[m]) begin
                // The abort ends the request, so the queue entry is dropped.
                evt.done[m] <= 1'b1;
                evt.pend[m] <= 1'b0;
            end else if (evt.pend[m] && fin[m]) begin
                // A lost arbitration keeps the message waiting for a retry.
                evt.arb[m] <= (kind == 2'h1);
                evt.ok[m] <= (kind == 2'h0);
                evt.err[m] <= (kind == 2'h2);
                evt.done[m] <= (kind != 2'h1);
                evt.pend[m] <= (kind == 2'h1);
            end
        end
        if (rst) begin
            evt <= '0;
        end
    end
endmodule : ctxs_engine_model

// [test/tb_can_tx_mailbox_status_flags.sv]
// Self-checking testbench of the transmit mailbox status flags.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module tb_can_tx_mailbox_status_flags;
    import ctxs_pkg::*;
    logic CLOCK = 0, SYS_RST = 1, HSEL = 0, HWRITE = 0, HREADYOUT, HRESP;
    logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, exp_st, q, wd;
    logic [1:0] HTRANS = 0, kind = 0;
    logic [2:0] HSIZE = 3'h2, go = 0, fin = 0, ABORT_REQ;
    ctxs_evt_type evt;
    int n_errors = 0, n_checks = 0, m, b;
    ctxs_top dut_u (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
        .TX_EVT(evt), .ABORT_REQ(ABORT_REQ));
    ctxs_engine_model eng_u (.clk(CLOCK), .rst(SYS_RST), .go(go), .fin(fin), .kind(kind),
        .abort_req(ABORT_REQ), .evt(evt));
    // Clock of 10 ns period.
    initial begin
        forever #5 CLOCK = ~CLOCK;
    end
    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    // Waits for hready with a bound, since a stuck slave must not hang the run.
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge CLOCK);
            k++;
        end while (HREADYOUT !== 1'b1 && k < 50);
        if (HREADYOUT !== 1'b1) begin
            n_errors++;
            end_sim();
        end
    endtask : wait_rdy
    // One single transfer at the current HSIZE; read data is taken at the data phase edge.
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        {HSEL, HTRANS, HWRITE, HADDR} <= {1'b1, 2'h2, w, a};
        wait_rdy();
        {HSEL, HTRANS, HWDATA} <= {1'b0, 2'h0, d};
        wait_rdy();
        q = HRDATA;
        `CHK("hresp", 1'b0, HRESP)
    endtask : bus
    // Reads the status word and compares it with the expected flags.
    task automatic chk_st();
        bus(1'b0, {20'h0, CTXS_STATUS_OFS}, 32'h0);
        `CHK("status", exp_st, q)
    endtask : chk_st
    // Flags that a write of d leaves standing; only the four flag bits of each mailbox clear.
    function automatic logic [31:0] after_w1c(input logic [31:0] st, input logic [31:0] d);
        return st & ~(d & 32'h000f0f0f);
    endfunction : after_w1c
    // One cycle command pulse to the engine model.
    task automatic pulse(input logic is_go);
        @(posedge CLOCK);
        if (is_go) go <= 3'h1 << m;
        else fin <= 3'h1 << m;
        @(posedge CLOCK);
        {go, fin} <= 6'h00;
        repeat (3) @(posedge CLOCK);
    endtask : pulse
    // Main sequence: every mailbox meets every outcome, with random clear words.
    initial begin
        wd = $urandom(32'hd83d);
        exp_st = CTXS_RDATA_RST;
        repeat (4) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        chk_st();
        for (int i = 0; i < 9; i++) begin
            m = i % 3;
            b = m * 8;
            kind <= 2'((i / 3) % 3);
            pulse(1'b1);
            exp_st[b] = 1'b0;
            chk_st();
            pulse(1'b0);
            exp_st[b] = (kind != 2'h1);
            exp_st[b + 1] |= (kind == 2'h0);
            exp_st[b + 2] |= (kind == 2'h1);
            exp_st[b + 3] |= (kind == 2'h2);
            chk_st();
            if (kind == 2'h1) begin
                bus(1'b1, {20'h0, CTXS_STATUS_OFS}, 32'h1 << (b + 7));
                @(posedge CLOCK);
                `CHK("abort_req", 1'b1, ABORT_REQ[m])
                repeat (4) @(posedge CLOCK);
                exp_st[b] = 1'b1;
                chk_st();
            end
            // Abort bits in random data hit empty mailboxes and must be ignored.
            wd = $urandom;
            bus(1'b1, {20'h0, CTXS_STATUS_OFS}, wd);
            // Look just after the write lands, before an empty mailbox could drop a wrong bit.
            #1;
            `CHK("abort_idle", 3'h0, ABORT_REQ)
            exp_st = after_w1c(exp_st, wd);
            chk_st();
            $display("test %0d done", i);
        end
        // Raise two flags first, so that a refused write of ones has something to clear.
        m = 1;
        kind <= 2'h0;
        pulse(1'b1);
        pulse(1'b0);
        exp_st[9:8] = 2'h3;
        // An unmapped place reads zero and a write there changes nothing.
        bus(1'b1, 32'h0000_000c, 32'hffff_ffff);
        bus(1'b0, 32'h0000_000c, 32'h0);
        `CHK("unmapped", CTXS_RDATA_RST, q)
        chk_st();
        $display("test unmapped done");
        // A half-word access to the status word is refused in the same way.
        HSIZE <= 3'h1;
        bus(1'b1, {20'h0, CTXS_STATUS_OFS}, 32'hffff_ffff);
        bus(1'b0, {20'h0, CTXS_STATUS_OFS}, 32'h0);
        `CHK("narrow", CTXS_RDATA_RST, q)
        HSIZE <= 3'h2;
        chk_st();
        $display("test narrow done");
        end_sim();
    end
endmodule : tb_can_tx_mailbox_status_flags
